// ---- src/rx_path_auto_ais_insertion.sv ----
// Receive path automatic AIS-P insertion control with its register port.
module rx_path_auto_ais_insertion (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire auto_ais_pkg::addr_t addr,
  input wire auto_ais_pkg::data_t wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [auto_ais_pkg::DATA_W-1:0] rd_data,
  input wire auto_ais_pkg::defect_s defects,
  output logic [auto_ais_pkg::E1_PATHS-1:0] e1_ais_force,
  output logic ais_active
);
  import auto_ais_pkg::*;

  // Bundled register request.
  reg_req_s req;

  // Software-visible state.
  data_t auto_path_ais_control;
  data_t defect_status;
  data_t active_cause;
  data_t cause_event;
  data_t onset_count;

  // Individual control fields behind the control byte.
  logic ais_enable;
  logic c2_unstable_trigger;
  logic uneq_trigger;
  logic plm_trigger;
  logic trace_unstable_trigger;
  logic tim_trigger;
  logic lop_trigger;

  // Individual sticky event bits behind the event byte.
  logic los_event;
  logic c2_unstable_event;
  logic uneq_event;
  logic plm_event;
  logic trace_unstable_event;
  logic tim_event;
  logic lop_event;
  logic ais_in_event;

  // Decoder result and derived terms.
  data_t next_cause;
  logic next_active;
  logic onset;
  data_t next_rd_data;
  data_t next_count;

  // Strobe decode for the control write, the event write and the onset count read.
  logic wr_control;
  logic wr_event;
  logic rd_count;

  // Address match used by every strobe decode.
  function automatic logic reg_hit(input addr_t a, input addr_t offset);
    reg_hit = (a == offset);
  endfunction

  // Saturating increment for the onset counter.
  function automatic data_t sat_inc(input data_t v);
    if (v == COUNT_MAX) begin
      sat_inc = v;
    end else begin
      sat_inc = v + COUNT_ONE;
    end
  endfunction

  // Next value of one sticky event bit; a cause present in the clearing cycle keeps it set.
  function automatic logic sticky_next(input logic cur, input logic clear, input logic cause);
    sticky_next = (cur & ~clear) | cause;
  endfunction

  // Gather the port signals into one request.
  assign req.addr = addr;
  assign req.wdata = wr_data;
  assign req.wr = wr_en;
  assign req.rd = rd_en;

  // Strobe decodes.
  assign wr_control = req.wr & reg_hit(req.addr, AUTO_PATH_AIS_CONTROL_ADDR);
  assign wr_event = req.wr & reg_hit(req.addr, CAUSE_EVENT_ADDR);
  assign rd_count = req.rd & reg_hit(req.addr, ONSET_COUNT_ADDR);

  // Cause decoding from the live control byte and the declared defects.
  ais_cause_decode u_decode (
    .control(auto_path_ais_control),
    .defects(defects),
    .cause(next_cause)
  );

  // Insertion is wanted while any cause holds.
  assign next_active = |next_cause;

  // An onset is the first cycle of an insertion episode.
  assign onset = next_active & ~ais_active;

  // Master enable; no cause forces AIS-P while it is clear.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ais_enable <= CONTROL_RESET[BIT_ENABLE];
    end else if (wr_control) begin
      ais_enable <= req.wdata[BIT_ENABLE];
    end
  end

  // Loss-of-pointer trigger, effective only beside the master enable.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lop_trigger <= CONTROL_RESET[BIT_LOP];
    end else if (wr_control) begin
      lop_trigger <= req.wdata[BIT_LOP];
    end
  end

  // Trace-identifier-mismatch trigger.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tim_trigger <= CONTROL_RESET[BIT_TIM];
    end else if (wr_control) begin
      tim_trigger <= req.wdata[BIT_TIM];
    end
  end

  // Unstable-trace trigger.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trace_unstable_trigger <= CONTROL_RESET[BIT_TRACE_UNSTABLE];
    end else if (wr_control) begin
      trace_unstable_trigger <= req.wdata[BIT_TRACE_UNSTABLE];
    end
  end

  // Payload-label-mismatch trigger.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      plm_trigger <= CONTROL_RESET[BIT_PLM];
    end else if (wr_control) begin
      plm_trigger <= req.wdata[BIT_PLM];
    end
  end

  // Unequipped-path trigger.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      uneq_trigger <= CONTROL_RESET[BIT_UNEQ];
    end else if (wr_control) begin
      uneq_trigger <= req.wdata[BIT_UNEQ];
    end
  end

  // Unstable-C2 trigger.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      c2_unstable_trigger <= CONTROL_RESET[BIT_C2_UNSTABLE];
    end else if (wr_control) begin
      c2_unstable_trigger <= req.wdata[BIT_C2_UNSTABLE];
    end
  end

  // Control byte as software and the decoder see it; the unimplemented top bit stays zero.
  always_comb begin
    auto_path_ais_control = ZERO_BYTE;
    auto_path_ais_control[BIT_ENABLE] = ais_enable;
    auto_path_ais_control[BIT_LOP] = lop_trigger;
    auto_path_ais_control[BIT_TIM] = tim_trigger;
    auto_path_ais_control[BIT_TRACE_UNSTABLE] = trace_unstable_trigger;
    auto_path_ais_control[BIT_PLM] = plm_trigger;
    auto_path_ais_control[BIT_UNEQ] = uneq_trigger;
    auto_path_ais_control[BIT_C2_UNSTABLE] = c2_unstable_trigger;
  end

  // Snapshot of the declared defects for software to read.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      defect_status <= ZERO_BYTE;
    end else begin
      defect_status <= defects;
    end
  end

  // Causes currently forcing AIS-P, registered beside the output.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_cause <= ZERO_BYTE;
    end else begin
      active_cause <= next_cause;
    end
  end

  // Forced AIS-P toward all egress paths tracks the causes cycle by cycle.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      e1_ais_force <= E1_NONE;
    end else if (next_active) begin
      e1_ais_force <= E1_ALL;
    end else begin
      e1_ais_force <= E1_NONE;
    end
  end

  // Summary flag that insertion is in force.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ais_active <= 1'b0;
    end else begin
      ais_active <= next_active;
    end
  end

  // Sticky event for loss of signal; write one to clear, a new cause in the same cycle wins.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      los_event <= ZERO_BYTE[BIT_LOS];
    end else begin
      los_event <= sticky_next(los_event, wr_event & req.wdata[BIT_LOS], next_cause[BIT_LOS]);
    end
  end

  // Sticky event for the unstable C2 byte.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      c2_unstable_event <= ZERO_BYTE[BIT_C2_UNSTABLE];
    end else begin
      c2_unstable_event <= sticky_next(c2_unstable_event, wr_event & req.wdata[BIT_C2_UNSTABLE],
        next_cause[BIT_C2_UNSTABLE]);
    end
  end

  // Sticky event for an unequipped path.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      uneq_event <= ZERO_BYTE[BIT_UNEQ];
    end else begin
      uneq_event <= sticky_next(uneq_event, wr_event & req.wdata[BIT_UNEQ], next_cause[BIT_UNEQ]);
    end
  end

  // Sticky event for a payload label mismatch.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      plm_event <= ZERO_BYTE[BIT_PLM];
    end else begin
      plm_event <= sticky_next(plm_event, wr_event & req.wdata[BIT_PLM], next_cause[BIT_PLM]);
    end
  end

  // Sticky event for an unstable trace message.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trace_unstable_event <= ZERO_BYTE[BIT_TRACE_UNSTABLE];
    end else begin
      trace_unstable_event <= sticky_next(trace_unstable_event, wr_event & req.wdata[BIT_TRACE_UNSTABLE],
        next_cause[BIT_TRACE_UNSTABLE]);
    end
  end

  // Sticky event for a trace identifier mismatch.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tim_event <= ZERO_BYTE[BIT_TIM];
    end else begin
      tim_event <= sticky_next(tim_event, wr_event & req.wdata[BIT_TIM], next_cause[BIT_TIM]);
    end
  end

  // Sticky event for loss of pointer.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lop_event <= ZERO_BYTE[BIT_LOP];
    end else begin
      lop_event <= sticky_next(lop_event, wr_event & req.wdata[BIT_LOP], next_cause[BIT_LOP]);
    end
  end

  // Sticky event for incoming AIS-P that was passed on.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ais_in_event <= ZERO_BYTE[BIT_AIS_IN];
    end else begin
      ais_in_event <= sticky_next(ais_in_event, wr_event & req.wdata[BIT_AIS_IN], next_cause[BIT_AIS_IN]);
    end
  end

  // Event byte as software reads it.
  always_comb begin
    cause_event = ZERO_BYTE;
    cause_event[BIT_LOS] = los_event;
    cause_event[BIT_C2_UNSTABLE] = c2_unstable_event;
    cause_event[BIT_UNEQ] = uneq_event;
    cause_event[BIT_PLM] = plm_event;
    cause_event[BIT_TRACE_UNSTABLE] = trace_unstable_event;
    cause_event[BIT_TIM] = tim_event;
    cause_event[BIT_LOP] = lop_event;
    cause_event[BIT_AIS_IN] = ais_in_event;
  end

  // Onset counter, cleared by reading it; an onset in the read cycle counts as one.
  always_comb begin
    next_count = onset_count;
    if (rd_count) begin
      next_count = ZERO_BYTE;
    end
    if (onset) begin
      next_count = sat_inc(next_count);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      onset_count <= ZERO_BYTE;
    end else begin
      onset_count <= next_count;
    end
  end

  // Read multiplexer; unmapped addresses read as zero.
  always_comb begin
    next_rd_data = ZERO_BYTE;
    if (req.rd) begin
      if (reg_hit(req.addr, AUTO_PATH_AIS_CONTROL_ADDR)) begin
        next_rd_data = auto_path_ais_control & CONTROL_WRITE_MASK;
      end else if (reg_hit(req.addr, DEFECT_STATUS_ADDR)) begin
        next_rd_data = defect_status;
      end else if (reg_hit(req.addr, ACTIVE_CAUSE_ADDR)) begin
        next_rd_data = active_cause;
      end else if (reg_hit(req.addr, CAUSE_EVENT_ADDR)) begin
        next_rd_data = cause_event;
      end else if (reg_hit(req.addr, ONSET_COUNT_ADDR)) begin
        next_rd_data = onset_count;
      end
    end
  end

  // Read data stands for exactly one cycle after the read strobe.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= ZERO_BYTE;
    end else begin
      rd_data <= next_rd_data;
    end
  end

endmodule

// ---- src/auto_ais_pkg.sv ----
// Constants, register map and signal groups for the receive path automatic AIS-P insertion block.
//
// Function
// - Unstable C2 plus enable forces AIS-P.
// - UNEQ-P plus enable forces AIS-P.
// - PLM-P plus enable forces AIS-P.
// - Unstable trace plus enable forces AIS-P.
// - TIM-P plus enable forces AIS-P.
// - LOP-P plus enable forces AIS-P.
// - Trigger bits act only with master enable.
// - Enable forwards incoming AIS-P; clear blocks all.
// - Loss of signal gated by enable alone.
// - All 28 E1 paths follow defect duration.
package auto_ais_pkg;

  // Register bus geometry.
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DATA_W-1:0] data_t;

  // Register offsets.
  localparam addr_t AUTO_PATH_AIS_CONTROL_ADDR = 12'h2BB;
  localparam addr_t DEFECT_STATUS_ADDR = 12'h2BC;
  localparam addr_t ACTIVE_CAUSE_ADDR = 12'h2BD;
  localparam addr_t CAUSE_EVENT_ADDR = 12'h2BE;
  localparam addr_t ONSET_COUNT_ADDR = 12'h2BF;

  // Reset values and counter constants.
  localparam data_t CONTROL_RESET = 8'h00;
  localparam data_t ZERO_BYTE = 8'h00;
  localparam data_t COUNT_MAX = 8'hFF;
  localparam data_t COUNT_ONE = 8'h01;

  // Bit positions shared by the control, status, cause and event registers.
  localparam int BIT_LOS = 7;
  localparam int BIT_C2_UNSTABLE = 6;
  localparam int BIT_UNEQ = 5;
  localparam int BIT_PLM = 4;
  localparam int BIT_TRACE_UNSTABLE = 3;
  localparam int BIT_TIM = 2;
  localparam int BIT_LOP = 1;
  localparam int BIT_ENABLE = 0;
  localparam int BIT_AIS_IN = 0;

  // Writable bits of the control register; the top bit is not implemented.
  localparam data_t CONTROL_WRITE_MASK = 8'h7F;

  // Number of egress E1 framer paths fed with forced AIS-P.
  localparam int E1_PATHS = 28;
  typedef logic [E1_PATHS-1:0] e1_vec_t;
  localparam e1_vec_t E1_ALL = 28'hFFFFFFF;
  localparam e1_vec_t E1_NONE = 28'h0000000;

  // Path defects declared by the receive overhead processor.
  typedef struct packed {
    logic los;
    logic c2_unstable;
    logic uneq;
    logic plm;
    logic trace_unstable;
    logic tim;
    logic lop;
    logic ais;
  } defect_s;

  // Software register access from the control port.
  typedef struct packed {
    addr_t addr;
    data_t wdata;
    logic wr;
    logic rd;
  } reg_req_s;

endpackage

// ---- src/ais_cause_decode.sv ----
// Decoder that turns the control byte and declared defects into the AIS-P cause vector.
module ais_cause_decode (
  input wire auto_ais_pkg::data_t control,
  input wire auto_ais_pkg::defect_s defects,
  output logic [auto_ais_pkg::DATA_W-1:0] cause
);
  import auto_ais_pkg::*;

  logic enable;

  // Master enable gates every cause below.
  assign enable = control[BIT_ENABLE];

  // Each cause bit holds while its defect is declared and its trigger is set; loss of signal and incoming AIS-P need only the enable.
  always_comb begin
    cause = ZERO_BYTE;
    cause[BIT_C2_UNSTABLE] = enable & control[BIT_C2_UNSTABLE] & defects.c2_unstable;
    cause[BIT_UNEQ] = enable & control[BIT_UNEQ] & defects.uneq;
    cause[BIT_PLM] = enable & control[BIT_PLM] & defects.plm;
    cause[BIT_TRACE_UNSTABLE] = enable & control[BIT_TRACE_UNSTABLE] & defects.trace_unstable;
    cause[BIT_TIM] = enable & control[BIT_TIM] & defects.tim;
    cause[BIT_LOP] = enable & control[BIT_LOP] & defects.lop;
    cause[BIT_LOS] = enable & defects.los;
    cause[BIT_AIS_IN] = enable & defects.ais;
  end

endmodule

// ---- testbench/auto_ais_sva.sv ----
// Assertion checker for the automatic AIS-P insertion ports.
module auto_ais_sva (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire auto_ais_pkg::addr_t addr,
  input wire auto_ais_pkg::data_t wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [auto_ais_pkg::DATA_W-1:0] rd_data,
  input wire auto_ais_pkg::defect_s defects,
  input wire logic [auto_ais_pkg::E1_PATHS-1:0] e1_ais_force,
  input wire logic ais_active
);
  timeunit 1ns;
  timeprecision 1ns;
  import auto_ais_pkg::*;
  logic [6:0] ctl;
  logic en;
  logic hit;
  // Shadow of the control byte, built from the writes seen on the port.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) ctl <= '0;
    else if (wr_en && addr == AUTO_PATH_AIS_CONTROL_ADDR) ctl <= wr_data[6:0];
  end
  // Any cause that should force AIS-P at the next edge.
  assign en = ctl[BIT_ENABLE];
  assign hit = en && (defects.los || defects.ais || (defects.uneq && ctl[BIT_UNEQ]) ||
    (defects.plm && ctl[BIT_PLM]) || (defects.lop && ctl[BIT_LOP]) ||
    (defects.c2_unstable && ctl[6]) || (defects.trace_unstable && ctl[3]) || (defects.tim && ctl[2]));
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_rd;
    rd_en && addr == AUTO_PATH_AIS_CONTROL_ADDR;
  endsequence
  AST_C2: assert property (en && ctl[6] && defects.c2_unstable |=> e1_ais_force == E1_ALL)
    else $error("no AIS on unstable C2");
  AST_UNEQ: assert property (en && ctl[BIT_UNEQ] && defects.uneq |=> e1_ais_force == E1_ALL)
    else $error("no AIS on UNEQ");
  AST_PLM: assert property (en && ctl[BIT_PLM] && defects.plm |=> e1_ais_force == E1_ALL)
    else $error("no AIS on PLM");
  AST_TRACE: assert property (en && ctl[3] && defects.trace_unstable |=> e1_ais_force == E1_ALL)
    else $error("no AIS on unstable trace");
  AST_TIM: assert property (en && ctl[2] && defects.tim |=> e1_ais_force == E1_ALL) else $error("no AIS on TIM");
  AST_LOP: assert property (en && ctl[BIT_LOP] && defects.lop |=> e1_ais_force == E1_ALL)
    else $error("no AIS on LOP");
  AST_AIS: assert property (en && defects.ais |=> ais_active) else $error("incoming AIS not sent on");
  AST_LOS: assert property (en && defects.los |=> ais_active) else $error("no AIS on loss of signal");
  AST_DROP: assert property (!hit |=> e1_ais_force == E1_NONE && !ais_active) else $error("AIS without cause");
  AST_ALL: assert property (ais_active == (e1_ais_force == E1_ALL)) else $error("paths disagree");
  AST_RD: assert property (s_rd |=> rd_data == {1'b0, $past(ctl)}) else $error("control readback wrong");
endmodule

bind rx_path_auto_ais_insertion auto_ais_sva u_sva (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .defects(defects),
  .e1_ais_force(e1_ais_force), .ais_active(ais_active));

// ---- testbench/e1_egress_bank.sv ----
// Model of the egress E1 framers that send AIS while forced.
module e1_egress_bank (
  input wire logic [auto_ais_pkg::E1_PATHS-1:0] e1_ais_force,
  output logic [4:0] ais_paths
);
  timeunit 1ns;
  timeprecision 1ns;
  import auto_ais_pkg::*;
  // Each framer sends AIS for as long as its own force line is high.
  always_comb begin
    ais_paths = '0;
    for (int i = 0; i < E1_PATHS; i++) ais_paths += 5'(e1_ais_force[i]);
  end
endmodule

// ---- testbench/rx_path_auto_ais_insertion_tb.sv ----
// Testbench for the automatic AIS-P insertion block.
module rx_path_auto_ais_insertion_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import auto_ais_pkg::*;
  localparam data_t ENABLE_ONLY = 8'h81; // Loss of signal and incoming AIS-P need the enable bit alone.
  logic sys_clk = 0;
  logic rst_n = 0;
  logic wr_en = 0;
  logic rd_en = 0;
  addr_t addr = '0;
  data_t wr_data = '0;
  defect_s defects = '0;
  logic [DATA_W-1:0] rd_data;
  logic [E1_PATHS-1:0] e1_ais_force;
  logic ais_active;
  logic [4:0] ais_paths;
  int errors = 0;
  int compares = 0;
  data_t v;

  // Clock of 50 ns period.
  always #25 sys_clk = ~sys_clk;

  rx_path_auto_ais_insertion u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .defects(defects), .e1_ais_force(e1_ais_force),
    .ais_active(ais_active));
  e1_egress_bank u_bank (.e1_ais_force(e1_ais_force), .ais_paths(ais_paths));

  task automatic cmp_byte(input string name, input data_t exp, input data_t got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s exp %h got %h", name, exp, got);
    end
  endtask

  task automatic cmp_out(input logic on);
    compares++;
    if (e1_ais_force !== (on ? E1_ALL : E1_NONE) || ais_active !== on || ais_paths !== (on ? 5'd28 : 5'd0)) begin
      errors++;
      $display("[ERR] ais_paths exp %0d got %0d", on ? 28 : 0, ais_paths);
    end
  endtask

  task automatic reg_wr(input addr_t a, input data_t d);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask

  task automatic reg_rd(input addr_t a, output data_t d);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask

  task automatic settle(input defect_s d);
    @(posedge sys_clk);
    defects <= d;
    @(posedge sys_clk);
    #1;
  endtask

  // Reset value, unused top bit, unmapped address and a second reset.
  task automatic t_regs();
    reg_rd(AUTO_PATH_AIS_CONTROL_ADDR, v);
    cmp_byte("control", 8'h00, v);
    reg_wr(AUTO_PATH_AIS_CONTROL_ADDR, 8'hFF);
    reg_rd(AUTO_PATH_AIS_CONTROL_ADDR, v);
    cmp_byte("control", 8'h7F, v);
    reg_rd(12'h000, v);
    cmp_byte("unmapped", 8'h00, v);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    @(posedge sys_clk);
    rst_n <= 1'b1;
    reg_rd(AUTO_PATH_AIS_CONTROL_ADDR, v);
    cmp_byte("control", 8'h00, v);
  endtask

  // Every defect alone under triggers without enable, enable only, all bits and two split trigger sets.
  task automatic t_matrix();
    data_t c[5] = '{8'h7E, 8'h01, 8'h7F, 8'h55, 8'h2B};
    foreach (c[k]) begin
      reg_wr(AUTO_PATH_AIS_CONTROL_ADDR, c[k]);
      for (int i = 0; i < 8; i++) begin
        settle(defect_s'(8'h01 << i));
        cmp_out(c[k][0] && (ENABLE_ONLY[i] || c[k][i]));
      end
      settle('0);
      cmp_out(1'b0);
    end
  endtask

  // Insertion lasts as long as the defect, and stops when enable is cleared.
  task automatic t_duration();
    reg_wr(AUTO_PATH_AIS_CONTROL_ADDR, 8'h03);
    settle(defect_s'(8'h02));
    repeat (4) begin
      cmp_out(1'b1);
      @(posedge sys_clk);
      #1;
    end
    reg_wr(AUTO_PATH_AIS_CONTROL_ADDR, 8'h00);
    @(posedge sys_clk);
    #1 cmp_out(1'b0);
  endtask

  // Status registers: defect snapshot, live causes, sticky events and the onset count.
  task automatic t_status();
    reg_wr(AUTO_PATH_AIS_CONTROL_ADDR, 8'h03);
    settle(defect_s'(8'h02));
    reg_rd(DEFECT_STATUS_ADDR, v);
    cmp_byte("defect_status", 8'h02, v);
    reg_rd(ACTIVE_CAUSE_ADDR, v);
    cmp_byte("active_cause", 8'h02, v);
    reg_wr(CAUSE_EVENT_ADDR, 8'hFF);
    reg_rd(CAUSE_EVENT_ADDR, v);
    cmp_byte("cause_event", 8'h02, v);
    reg_rd(ONSET_COUNT_ADDR, v);
    settle('0);
    settle(defect_s'(8'h02));
    reg_rd(ONSET_COUNT_ADDR, v);
    cmp_byte("onset_count", 8'h01, v);
    settle('0);
    cmp_out(1'b0);
  endtask

  task automatic print_verdict();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Main sequence after five cycles of reset.
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs();
    t_matrix();
    t_duration();
    t_status();
    print_verdict();
  end

  // Watchdog well beyond the 150 or so cycles the tests need.
  initial begin
    #1000000;
    errors++;
    print_verdict();
  end
endmodule
